// ---- hw/slsf_top.v ----
// Functional notes
// - One alignment status bit per lane, 1=aligned
// - Disparity flag set when count reaches threshold
// - Disparity flags gathered at index 0x46d
// - Alignment and disparity status bits read-only, reset to zero
`timescale 1ns/1ps
`include "slsf_defs.vh"
module slsf_top (
    input  wire        ref_clk,        // 250 MHz logic clock
    input  wire        rst_b,          // Async reset, active low
    input  wire        psel,           // APB select
    input  wire        penable,        // APB access phase
    input  wire        pwrite,         // APB direction
    input  wire [13:0] paddr,          // APB byte address
    input  wire [31:0] pwdata,         // APB write data
    output wire        pready,         // APB ready
    output reg  [31:0] prdata,         // APB read data
    output wire        pslverr,        // APB error
    input  wire [7:0]  lane_aligned,   // Per-lane deskew result, from receivers
    input  wire [7:0]  lane_disp_err,  // Per-lane disparity violation pulses
    output reg         skip_initial_alignment, // Skip alignment sequence option
    output wire        irq             // Level interrupt
);
    reg  [7:0]  error_count_threshold; // Shared threshold
    reg  [7:0]  align_s1;              // Sync stage 1
    reg  [7:0]  align_s2;              // Sync stage 2
    reg  [7:0]  align_s3;              // Sync stage 3
    reg  [7:0]  lane_alignment_status; // Debounced alignment bits
    reg  [7:0]  cnt_clear;             // Counter clear strobe
    reg  [15:0] irq_status;            // Sticky events
    reg  [15:0] irq_mask;              // Enable per event
    reg  [7:0]  disp_prev;             // Previous fault flags
    wire [7:0]  lane_disparity_fault_flags; // Per-lane fault flags
    wire [15:0] events;                // Event pulses this cycle
    wire        wr_en;                 // Write completes
    wire        rd_en;                 // Read setup phase
    wire        addr_ok;               // Address mapped

    // True when address hits a mapped register
    function addr_hit;
        input [13:0] a;
        begin
            addr_hit = (a == `SLSF_ADDR_ALIGN) || (a == `SLSF_ADDR_DISP) ||
                       (a == `SLSF_ADDR_IRQ_STAT) || (a == `SLSF_ADDR_IRQ_MASK) ||
                       (a == `SLSF_ADDR_CTRL);
        end
    endfunction

    // Zero-wait APB slave
    assign pready  = 1'b1;
    assign addr_ok = addr_hit(paddr);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;

    // Alignment inputs from receivers: three stages, accept when 2 and 3 agree
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            align_s1              <= `SLSF_RST_STATUS;
            align_s2              <= `SLSF_RST_STATUS;
            align_s3              <= `SLSF_RST_STATUS;
            lane_alignment_status <= `SLSF_RST_STATUS;
        end else begin
            align_s1 <= lane_aligned;
            align_s2 <= align_s1;
            align_s3 <= align_s2;
            lane_alignment_status <= (align_s2 & align_s3) |
                                     (lane_alignment_status & (align_s2 | align_s3));
        end
    end

    // One saturating counter per lane
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : lane
            slsf_lane_counter u_cnt (
                .ref_clk   (ref_clk),
                .rst_b     (rst_b),
                .clear     (cnt_clear[g]),
                .err_pulse (lane_disp_err[g]),
                .threshold (error_count_threshold),
                .count     (),
                .fault     (lane_disparity_fault_flags[g])
            );
        end
    endgenerate

    // Events: fault flag rises, alignment lost
    assign events = {lane_alignment_status & ~align_s2 & ~align_s3,
                     lane_disparity_fault_flags & ~disp_prev};

    // Control, mask and sticky status; set wins over clear
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            error_count_threshold  <= `SLSF_RST_THR;
            skip_initial_alignment <= 1'b0;
            cnt_clear              <= 8'h00;
            irq_mask               <= `SLSF_RST_MASK;
            irq_status             <= 16'h0000;
            disp_prev              <= 8'h00;
        end else begin
            disp_prev <= lane_disparity_fault_flags;
            cnt_clear <= 8'h00;
            if (wr_en && paddr == `SLSF_ADDR_CTRL) begin
                error_count_threshold  <= pwdata[`SLSF_CTRL_THR_MSB:`SLSF_CTRL_THR_LSB];
                skip_initial_alignment <= pwdata[`SLSF_CTRL_SKIP_BIT];
                cnt_clear              <= {8{pwdata[`SLSF_CTRL_CLR_BIT]}};
            end
            if (wr_en && paddr == `SLSF_ADDR_IRQ_MASK) begin
                irq_mask <= pwdata[15:0];
            end
            if (wr_en && paddr == `SLSF_ADDR_IRQ_STAT) begin
                irq_status <= (irq_status & ~pwdata[15:0]) | events;
            end else begin
                irq_status <= irq_status | events;
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data captured in setup phase; alignment and disparity status registers have no write path
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `SLSF_ADDR_ALIGN:    prdata <= {24'h000000, lane_alignment_status};
                `SLSF_ADDR_DISP:     prdata <= {24'h000000, lane_disparity_fault_flags};
                `SLSF_ADDR_IRQ_STAT: prdata <= {16'h0000, irq_status};
                `SLSF_ADDR_IRQ_MASK: prdata <= {16'h0000, irq_mask};
                `SLSF_ADDR_CTRL:     prdata <= {23'h000000, skip_initial_alignment,
                                                error_count_threshold};
                default:             prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ---- hw/slsf_defs.vh ----
`ifndef SLSF_DEFS_VH
`define SLSF_DEFS_VH
// Register indices as printed; byte address is four times the index
`define SLSF_IDX_ALIGN      12'h46c
`define SLSF_IDX_DISP       12'h46d
`define SLSF_IDX_IRQ_STAT   12'h470
`define SLSF_IDX_IRQ_MASK   12'h471
`define SLSF_IDX_CTRL       12'h472
// Byte addresses
`define SLSF_ADDR_ALIGN     14'h11b0
`define SLSF_ADDR_DISP      14'h11b4
`define SLSF_ADDR_IRQ_STAT  14'h11c0
`define SLSF_ADDR_IRQ_MASK  14'h11c4
`define SLSF_ADDR_CTRL      14'h11c8
// Control register fields
`define SLSF_CTRL_THR_LSB   0
`define SLSF_CTRL_THR_MSB   7
`define SLSF_CTRL_SKIP_BIT  8
`define SLSF_CTRL_CLR_BIT   9
// Interrupt status fields: [7:0] disparity fault rise, [15:8] alignment loss
`define SLSF_IRQ_DISP_LSB   0
`define SLSF_IRQ_ALIGN_LSB  8
// Reset values
`define SLSF_RST_STATUS     8'h00
`define SLSF_RST_THR        8'hff
`define SLSF_RST_MASK       16'h0000
`define SLSF_CNT_MAX        8'hff
`endif

// ---- hw/slsf_lane_counter.v ----
`timescale 1ns/1ps
`include "slsf_defs.vh"
// Saturating disparity error counter for one lane
module slsf_lane_counter (
    input  wire       ref_clk,      // Link logic clock
    input  wire       rst_b,        // Async reset, active low
    input  wire       clear,        // Restart count
    input  wire       err_pulse,    // One disparity violation
    input  wire [7:0] threshold,    // Shared error threshold
    output reg  [7:0] count,        // Current count
    output reg        fault         // Count at or above threshold
);
    // Count up, stop at all ones rather than wrap
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
        end else if (clear) begin
            count <= 8'h00;
        end else if (err_pulse && count != `SLSF_CNT_MAX) begin
            count <= count + 8'h01;
        end
    end

    // Registered compare against threshold
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault <= 1'b0;
        end else begin
            fault <= (count >= threshold);
        end
    end
endmodule

// ---- verification/slsf_top_sva.sv ----
`timescale 1ns/1ps
`include "slsf_defs.vh"
// Port-level checks beside the lane status block
module slsf_top_sva (
    input logic        ref_clk,      // Logic clock
    input logic        rst_b,        // Reset, active low
    input logic        psel,         // Select
    input logic        penable,      // Access phase
    input logic        pwrite,       // Direction
    input logic [13:0] paddr,        // Byte address
    input logic [31:0] prdata,       // Read data
    input logic        irq,          // Interrupt
    input logic        skip_initial_alignment, // Skip option
    input logic [7:0]  lane_aligned  // Deskew inputs
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_align_read_value:
        assert property ($stable(lane_aligned)[*5] ##0 (psel && !penable && !pwrite
            && paddr == `SLSF_ADDR_ALIGN) |=> prdata == {24'h0, $past(lane_aligned)})
        else $error("alignment read mismatch");
    a_disp_upper_zero:
        assert property (psel && penable && !pwrite && paddr == `SLSF_ADDR_DISP
            |-> prdata[31:8] == 24'h0) else $error("disparity read upper bits set");
    a_reset_outputs:
        assert property ($rose(rst_b) |-> prdata == 32'h0 && !irq)
        else $error("outputs not clear after reset");
    a_align_upper_zero:
        assert property (psel && penable && !pwrite && paddr == `SLSF_ADDR_ALIGN
            |-> prdata[31:8] == 24'h0) else $error("alignment read upper bits set");
    a_skip_after_reset:
        assert property ($rose(rst_b) |-> !skip_initial_alignment)
        else $error("skip option not clear after reset");
endmodule
bind slsf_top slsf_top_sva chk (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .prdata, .irq, .skip_initial_alignment, .lane_aligned);

// ---- verification/slsf_lane_tx.sv ----
`timescale 1ns/1ps
// Far-end lane transmitter: deskew levels and violation pulses
module slsf_lane_tx (
    input  wire        ref_clk,              // Logic clock
    output logic [7:0] lane_aligned = 8'h00, // Deskew result per lane
    output logic [7:0] lane_disp_err = 8'h00 // One-cycle violation pulses
);
    // New deskew levels
    task set_align(input logic [7:0] v);
        @(posedge ref_clk);
        lane_aligned <= v;
    endtask
    // n violations on the masked lanes, idle cycle between
    task burst(input logic [7:0] m, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            lane_disp_err <= m;
            @(posedge ref_clk);
            lane_disp_err <= 8'h00;
        end
    endtask
endmodule

// ---- verification/serial_lane_status_flags_test.sv ----
`timescale 1ns/1ps
`include "slsf_defs.vh"
// Register-level bench for the lane status block
module serial_lane_status_flags_test;
    logic        ref_clk = 0, rst_b = 0;          // Clock, reset
    logic        psel = 0, penable = 0, pwrite = 0; // Bus controls
    logic [13:0] paddr = 0;                        // Byte address
    logic [31:0] pwdata = 0, rd;                   // Write data, read data
    logic        er;                               // Last error flag
    wire         pready, pslverr, irq, skip_initial_alignment; // Outputs
    wire  [31:0] prdata;                           // Read data
    wire  [7:0]  lane_aligned, lane_disp_err;      // Lane lines
    int          num_errors = 0, tests_run = 0;    // Counters
    always #2 ref_clk = ~ref_clk;
    slsf_top dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .lane_aligned, .lane_disp_err, .skip_initial_alignment, .irq);
    slsf_lane_tx tx (.ref_clk, .lane_aligned, .lane_disp_err);
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // One bus transfer, waits for ready
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d = 0);
        int n;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        num_errors += (n >= 20);
        {psel, penable} <= 2'b00;
    endtask
    // Verdict and end of run
    task finish_test;
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial begin
        #40000;
        num_errors++;
        finish_test;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1;
        apb(1, `SLSF_ADDR_ALIGN, 32'hffffffff);
        apb(1, `SLSF_ADDR_DISP, 32'hffffffff);
        apb(0, `SLSF_ADDR_ALIGN);
        chk(rd, 32'h0);
        apb(0, `SLSF_ADDR_DISP);
        chk(rd, 32'h0);
        tx.set_align(8'h15);
        repeat (6) @(posedge ref_clk);
        apb(0, `SLSF_ADDR_ALIGN);
        chk(rd, 32'h15);
        apb(1, `SLSF_ADDR_CTRL, 32'h3);
        tx.burst(8'h82, 2);
        apb(0, `SLSF_ADDR_DISP);
        chk(rd, 32'h0);
        tx.burst(8'h02, 1);
        apb(0, `SLSF_ADDR_DISP);
        chk(rd, 32'h2);
        tx.burst(8'h80, 1);
        apb(0, `SLSF_ADDR_DISP);
        chk(rd, 32'h82);
        apb(1, `SLSF_ADDR_CTRL, 32'hff);
        tx.burst(8'h01, 260);
        apb(0, `SLSF_ADDR_DISP);
        chk(rd, 32'h1);
        apb(0, `SLSF_ADDR_IRQ_STAT);
        chk(rd, 32'h83);
        apb(1, `SLSF_ADDR_IRQ_MASK, 32'h2);
        @(negedge ref_clk);
        chk(irq, 1);
        apb(1, `SLSF_ADDR_IRQ_STAT, 32'h2);
        @(negedge ref_clk);
        chk(irq, 0);
        apb(0, 14'h1000);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1, `SLSF_ADDR_CTRL, 32'h1ff);
        @(negedge ref_clk);
        chk(skip_initial_alignment, 1);
        finish_test;
    end
endmodule
